/* File: src/apdu_cfg.svh */
`ifndef APDU_CFG_SVH
`define APDU_CFG_SVH

// ************************************************************
// command header bytes
// ************************************************************
`define CLA_PSEUDO      8'hFF
`define INS_PLAIN       8'h00
`define INS_GET_RESP    8'hC0
`define P1_DIRECT       8'h00
`define P1_LAMP         8'h40
`define P2_ZERO         8'h00
`define LC_LAMP         8'h04
`define HDR_BYTES       9'h005
`define LAMP_CMD_BYTES  9'h009
`define CMD_MAX_BYTES   9'h104

// ************************************************************
// status words
// ************************************************************
`define SW1_MORE        8'h61
`define SW1_OK          8'h90
`define SW1_ERR         8'h63
`define SW2_NONE        8'h00
`define SW2_GENERAL     8'h00
`define SW2_TIMEOUT     8'h01
`define SW2_CHECKSUM    8'h27
`define SW2_PARAM       8'h7F

// ************************************************************
// state control byte fields, lamp i at lsb + i; buzzer link byte bits
// ************************************************************
`define CTRL_FIN_LSB    0
`define CTRL_MSK_LSB    2
`define CTRL_INI_LSB    4
`define CTRL_BLK_LSB    6
`define LINK_INI_BIT    0
`define LINK_TOG_BIT    1

// ************************************************************
// register offsets
// ************************************************************
`define REG_CMD_BYTE    8'h00
`define REG_CMD_EXEC    8'h04
`define REG_STATUS      8'h08
`define REG_RESP_DATA   8'h0C
`define REG_LAMP        8'h10
`define REG_RESP_LEFT   8'h14

// ************************************************************
// timing
// ************************************************************
`define CLK_MHZ         200
`define TICK_MS         100
`define FE_TIMEOUT_MS   500
`define TICK_CYCLES     (`TICK_MS * 1000 * `CLK_MHZ)
`define FE_TO_CYCLES    (`FE_TIMEOUT_MS * 1000 * `CLK_MHZ)

`endif

/* File: src/apdu_pkg.sv */
// ************************************************************
// shared types
// ************************************************************
package apdu_pkg;

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_INIT = 2'b01,
		SEQ_TOGG = 2'b10
	} seq_state_t;

	typedef enum logic [1:0] {
		FE_OK       = 2'b00,
		FE_GENERAL  = 2'b01,
		FE_CHECKSUM = 2'b10,
		FE_SPARE    = 2'b11
	} fe_res_t;

endpackage : apdu_pkg

/* File: src/tick_gen.sv */
`timescale 1ns/1ps
`default_nettype none
`include "apdu_cfg.svh"

module tick_gen
	import apdu_pkg::*;
#(
	parameter int unsigned CYCLES = `TICK_CYCLES
)
(
	input  wire logic core_clk, // system clock
	input  wire logic resetn,   // sync reset, low
	input  wire logic clear,    // restart the step
	output logic      tick_ff   // one-cycle step pulse
);

	localparam logic [31:0] LAST = 32'(CYCLES - 1);

	logic [31:0] cnt_ff;

	// ************************************************************
	// prescaler
	// ************************************************************
	// free count, realigned on each new sequence
	always_ff @(posedge core_clk)
	begin
		if (!resetn || clear)
			cnt_ff <= 32'h0;
		else if (cnt_ff >= LAST)
			cnt_ff <= 32'h0; // RULE20
		else
			cnt_ff <= cnt_ff + 32'h1;
	end

	// pulse on the last count
	always_ff @(posedge core_clk)
	begin
		if (!resetn || clear)
			tick_ff <= 1'b0;
		else
			tick_ff <= (cnt_ff >= LAST); // RULE20
	end

	a_tick_period: assert property (@(posedge core_clk) disable iff (!resetn) // RULE20
		$rose(tick_ff) |-> $past(cnt_ff) == LAST)
		else $error("tick not on last count");

endmodule : tick_gen

`default_nettype wire

/* File: src/blink_seq.sv */
`timescale 1ns/1ps
`default_nettype none
`include "apdu_cfg.svh"

module blink_seq
	import apdu_pkg::*;
(
	input  wire logic       core_clk, // system clock
	input  wire logic       resetn,   // sync reset, low
	input  wire logic       tick,     // 100 ms step
	input  wire logic       start,    // load a lamp command
	input  wire logic [7:0] ctrl_in,  // state control byte
	input  wire logic [7:0] ini_in,   // initial phase steps
	input  wire logic [7:0] tog_in,   // toggled phase steps
	input  wire logic [7:0] reps_in,  // repetitions
	input  wire logic [7:0] link_in,  // buzzer link
	output logic [1:0]      lamp_ff,  // {green, red}
	output logic            buzz_ff   // buzzer on
);

	seq_state_t state_ff;
	seq_state_t nxt_state;
	logic [7:0] ctrl_ff;
	logic [7:0] initial_phase_time_ff;
	logic [7:0] toggled_phase_time_ff;
	logic [7:0] reps_ff;
	logic [7:0] link_ff;
	logic [7:0] cnt_ff;
	logic [7:0] nxt_link;
	logic       done;
	logic       finish;

	// phase ends once its step count is reached
	assign done = (state_ff == SEQ_INIT) ? (cnt_ff >= initial_phase_time_ff) : // RULE14
		(cnt_ff >= toggled_phase_time_ff); // RULE14
	assign finish = (state_ff == SEQ_TOGG) && done && (reps_ff == 8'h01);
	assign nxt_link = start ? link_in : link_ff;

	// ************************************************************
	// sequence state
	// ************************************************************
	always_comb
	begin
		nxt_state = state_ff;
		if (start)
			nxt_state = (reps_in != 8'h00) ? SEQ_INIT : SEQ_IDLE; // RULE18
		else
			unique case (state_ff)
				SEQ_IDLE: nxt_state = SEQ_IDLE;
				SEQ_INIT: if (done) nxt_state = SEQ_TOGG; // RULE19
				SEQ_TOGG: if (done) nxt_state = finish ? SEQ_IDLE : SEQ_INIT; // RULE19
				default:  nxt_state = SEQ_IDLE;
			endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
			state_ff <= SEQ_IDLE;
		else
			state_ff <= nxt_state;
	end

	// latched command fields
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			ctrl_ff               <= 8'h00;
			initial_phase_time_ff <= 8'h00;
			toggled_phase_time_ff <= 8'h00;
			link_ff               <= 8'h00;
		end
		else if (start)
		begin
			ctrl_ff               <= ctrl_in;
			initial_phase_time_ff <= ini_in;
			toggled_phase_time_ff <= tog_in;
			link_ff               <= link_in;
		end
	end

	// repetitions left, counted down after each toggled phase
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
			reps_ff <= 8'h00;
		else if (start)
			reps_ff <= reps_in;
		else if ((state_ff == SEQ_TOGG) && done)
			reps_ff <= reps_ff - 8'h01; // RULE19
	end

	// steps spent in the current phase
	always_ff @(posedge core_clk)
	begin
		if (!resetn || start)
			cnt_ff <= 8'h00;
		else if ((state_ff != SEQ_IDLE) && done)
			cnt_ff <= 8'h00;
		else if ((state_ff != SEQ_IDLE) && tick)
			cnt_ff <= cnt_ff + 8'h01; // RULE14
	end

	// buzzer follows the phase it is linked to
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
			buzz_ff <= 1'b0;
		else
			buzz_ff <= ((nxt_state == SEQ_INIT) && nxt_link[`LINK_INI_BIT]) || // RULE15
				((nxt_state == SEQ_TOGG) && nxt_link[`LINK_TOG_BIT]); // RULE15
	end

	// ************************************************************
	// per lamp level
	// ************************************************************
	for (genvar i = 0; i < 2; i++)
	begin : g_lamp
		always_ff @(posedge core_clk)
		begin
			if (!resetn)
				lamp_ff[i] <= 1'b0;
			else if (start && (reps_in == 8'h00))
			begin
				if (ctrl_in[`CTRL_MSK_LSB + i]) // RULE11
					lamp_ff[i] <= ctrl_in[`CTRL_FIN_LSB + i]; // RULE11
			end
			else if (start)
			begin
				if (ctrl_in[`CTRL_BLK_LSB + i]) // RULE13
					lamp_ff[i] <= ctrl_in[`CTRL_INI_LSB + i]; // RULE12
			end
			else if (finish)
			begin
				if (ctrl_ff[`CTRL_MSK_LSB + i]) // RULE17
					lamp_ff[i] <= ctrl_ff[`CTRL_FIN_LSB + i]; // RULE17
			end
			else if (done && ctrl_ff[`CTRL_BLK_LSB + i])
			begin
				if (state_ff == SEQ_INIT)
					lamp_ff[i] <= ~ctrl_ff[`CTRL_INI_LSB + i]; // RULE19
				else if (state_ff == SEQ_TOGG)
					lamp_ff[i] <= ctrl_ff[`CTRL_INI_LSB + i]; // RULE12
			end
		end
	end

	a_zero_reps_idle: assert property (@(posedge core_clk) disable iff (!resetn) // RULE18
		start && (reps_in == 8'h00) |=> (state_ff == SEQ_IDLE) && !buzz_ff)
		else $error("zero repetitions started a sequence");

	a_no_blink_hold: assert property (@(posedge core_clk) disable iff (!resetn) // RULE13
		(state_ff != SEQ_IDLE) && !ctrl_ff[`CTRL_BLK_LSB] && !finish && !start
		|=> $stable(lamp_ff[0]))
		else $error("red lamp changed without blink mask");

	a_final_apply: assert property (@(posedge core_clk) disable iff (!resetn) // RULE17
		finish && !start && ctrl_ff[`CTRL_MSK_LSB + 1]
		|=> (lamp_ff[1] == $past(ctrl_ff[`CTRL_FIN_LSB + 1])) && (state_ff == SEQ_IDLE))
		else $error("final green level not applied");

endmodule : blink_seq

`default_nettype wire

/* File: src/apdu_handler.sv */
// Function
// RULE1 - pass-through success answers 61 and length
// RULE2 - general pass-through failure answers 63 00
// RULE3 - front end silent answers 63 01
// RULE4 - bad reply checksum answers 63 27
// RULE5 - malformed embedded command answers 63 7F
// RULE6 - FF C0 00 00 length fetches data
// RULE7 - one-byte length, at most 255 bytes
// RULE8 - fetch with nothing pending answers 63 00
// RULE9 - host fetches right after each pass-through
// RULE10 - lamp command: FF 00 40 ctrl 04 plus four
// RULE11 - final levels applied only where mask set
// RULE12 - bits 4,5 give initial blink levels
// RULE13 - bits 6,7 enable blinking per lamp
// RULE14 - bytes 0,1 phase steps, byte 2 repeats
// RULE15 - byte 3 links buzzer to phases
// RULE16 - lamp command answers 90 and levels
// RULE17 - final levels after whole blink sequence
// RULE18 - zero repetitions: no blink, no buzzer
// RULE19 - initial phase, inverted phase, then count
// RULE20 - prescaler makes the 100 ms step
`timescale 1ns/1ps
`default_nettype none
`include "apdu_cfg.svh"

module apdu_handler
	import apdu_pkg::*;
#(
	parameter int unsigned TICK_CYCLES  = `TICK_CYCLES,
	parameter int unsigned FE_TO_CYCLES = `FE_TO_CYCLES
)
(
	input  wire logic        core_clk,    // system clock
	input  wire logic        resetn,      // sync reset, low
	input  wire logic [7:0]  reg_addr,    // register byte address
	input  wire logic [31:0] reg_wdata,   // write data
	input  wire logic        reg_wr,      // write strobe
	input  wire logic        reg_rd,      // read strobe
	output logic      [31:0] reg_rdata,   // read data, next cycle
	output logic             fe_req,      // start front-end command
	output logic      [7:0]  fe_cmd_len,  // embedded command bytes
	input  wire logic [7:0]  fe_rd_addr,  // embedded byte index
	output logic      [7:0]  fe_rd_data,  // embedded byte, next cycle
	input  wire logic        fe_done,     // front end finished
	input  wire logic [1:0]  fe_status,   // front-end result
	input  wire logic [7:0]  fe_resp_len, // reply byte count
	input  wire logic        fe_wr,       // reply byte strobe
	input  wire logic [7:0]  fe_wr_data,  // reply byte
	output logic             red_led,     // red lamp on
	output logic             green_led,   // green lamp on
	output logic             buzzer       // buzzer on
);

	localparam logic [31:0] TO_LAST = 32'(FE_TO_CYCLES - 1);

	logic [7:0]  cmd_mem [0:259];
	logic [7:0]  resp_mem [0:255];
	logic [8:0]  cmd_cnt_ff;
	logic        cmd_ovf_ff;
	logic        busy_ff;
	logic        pending_ff;
	logic [7:0]  pending_response_length_ff;
	logic [7:0]  left_ff;
	logic [7:0]  rd_ptr_ff;
	logic [7:0]  wr_ptr_ff;
	logic [31:0] to_cnt_ff;
	logic [7:0]  sw1_ff;
	logic [7:0]  sw2_ff;
	logic        fe_req_ff;
	logic [7:0]  fe_cmd_len_ff;
	logic [7:0]  fe_rd_data_ff;
	logic [31:0] rdata_ff;
	logic [1:0]  lamp;
	logic        buzz;
	logic        tick;
	logic        exec_go;
	logic        hdr_ok;
	logic        is_pseudo;
	logic        lamp_cmd;
	logic        direct_cmd;
	logic        direct_ok;
	logic        get_cmd;
	logic        lamp_start;
	logic        fe_end;
	logic        fe_timeout;
	logic        resp_pop;
	logic [7:0]  get_len;

	// ************************************************************
	// command decode
	// ************************************************************
	// executes only while no front-end command is outstanding
	assign exec_go   = reg_wr && (reg_addr == `REG_CMD_EXEC) && !busy_ff;
	assign hdr_ok    = (cmd_cnt_ff >= `HDR_BYTES) && !cmd_ovf_ff;
	assign is_pseudo = hdr_ok && (cmd_mem[0] == `CLA_PSEUDO);
	assign lamp_cmd  = is_pseudo && (cmd_mem[1] == `INS_PLAIN) && (cmd_mem[2] == `P1_LAMP)
		&& (cmd_mem[4] == `LC_LAMP) && (cmd_cnt_ff == `LAMP_CMD_BYTES); // RULE10
	assign direct_cmd = is_pseudo && (cmd_mem[1] == `INS_PLAIN) && (cmd_mem[2] == `P1_DIRECT)
		&& (cmd_mem[3] == `P2_ZERO);
	assign direct_ok = direct_cmd && (cmd_mem[4] != 8'h00)
		&& (cmd_cnt_ff == ({1'b0, cmd_mem[4]} + `HDR_BYTES)); // RULE5
	assign get_cmd   = is_pseudo && (cmd_mem[1] == `INS_GET_RESP) && (cmd_mem[2] == `P2_ZERO)
		&& (cmd_mem[3] == `P2_ZERO) && (cmd_cnt_ff == `HDR_BYTES); // RULE6
	assign lamp_start = exec_go && lamp_cmd;
	// fetch length is one byte, clipped to what is waiting
	assign get_len   = (cmd_mem[4] < pending_response_length_ff) ? cmd_mem[4] : // RULE7
		pending_response_length_ff;
	assign fe_end     = busy_ff && fe_done;
	assign fe_timeout = busy_ff && !fe_done && (to_cnt_ff >= TO_LAST);
	assign resp_pop   = reg_rd && (reg_addr == `REG_RESP_DATA) && (left_ff != 8'h00);

	// ************************************************************
	// command and reply buffers
	// ************************************************************
	// bytes appended until executed; excess marks overflow
	always_ff @(posedge core_clk)
	begin
		if (!resetn || exec_go)
		begin
			cmd_cnt_ff <= 9'h000;
			cmd_ovf_ff <= 1'b0;
		end
		else if (reg_wr && (reg_addr == `REG_CMD_BYTE) && !busy_ff)
		begin
			if (cmd_cnt_ff < `CMD_MAX_BYTES)
				cmd_cnt_ff <= cmd_cnt_ff + 9'h001;
			else
				cmd_ovf_ff <= 1'b1;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (reg_wr && (reg_addr == `REG_CMD_BYTE) && !busy_ff && (cmd_cnt_ff < `CMD_MAX_BYTES))
			cmd_mem[cmd_cnt_ff] <= reg_wdata[7:0];
	end

	// front end reads the embedded command after the header
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
			fe_rd_data_ff <= 8'h00;
		else
			fe_rd_data_ff <= cmd_mem[9'({1'b0, fe_rd_addr} + `HDR_BYTES)];
	end

	// reply bytes land while the command is outstanding
	always_ff @(posedge core_clk)
	begin
		if (!resetn || fe_req_ff)
			wr_ptr_ff <= 8'h00;
		else if (busy_ff && fe_wr)
			wr_ptr_ff <= wr_ptr_ff + 8'h01;
	end

	always_ff @(posedge core_clk)
	begin
		if (busy_ff && fe_wr)
			resp_mem[wr_ptr_ff] <= fe_wr_data;
	end

	// ************************************************************
	// front-end handshake
	// ************************************************************
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			fe_req_ff     <= 1'b0;
			fe_cmd_len_ff <= 8'h00;
		end
		else
		begin
			fe_req_ff <= exec_go && direct_ok;
			if (exec_go && direct_ok)
				fe_cmd_len_ff <= cmd_mem[4];
		end
	end

	// busy until the reply or the timeout
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
			busy_ff <= 1'b0;
		else if (exec_go && direct_ok)
			busy_ff <= 1'b1;
		else if (fe_end || fe_timeout)
			busy_ff <= 1'b0; // RULE3
	end

	always_ff @(posedge core_clk)
	begin
		if (!resetn || !busy_ff)
			to_cnt_ff <= 32'h0;
		else
			to_cnt_ff <= to_cnt_ff + 32'h1; // RULE3
	end

	// ************************************************************
	// status words and pending reply
	// ************************************************************
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			sw1_ff <= `SW1_OK;
			sw2_ff <= `SW2_NONE;
		end
		else if (fe_end)
			unique case (fe_status)
				FE_OK:
				begin
					sw1_ff <= `SW1_MORE; // RULE1
					sw2_ff <= fe_resp_len; // RULE1
				end
				FE_CHECKSUM:
				begin
					sw1_ff <= `SW1_ERR; // RULE4
					sw2_ff <= `SW2_CHECKSUM; // RULE4
				end
				default:
				begin
					sw1_ff <= `SW1_ERR; // RULE2
					sw2_ff <= `SW2_GENERAL; // RULE2
				end
			endcase
		else if (fe_timeout)
		begin
			sw1_ff <= `SW1_ERR; // RULE3
			sw2_ff <= `SW2_TIMEOUT; // RULE3
		end
		else if (exec_go)
		begin
			if (lamp_cmd)
			begin
				sw1_ff <= `SW1_OK; // RULE16
				sw2_ff <= {6'h00, lamp}; // RULE16
			end
			else if (direct_cmd && !direct_ok)
			begin
				sw1_ff <= `SW1_ERR; // RULE5
				sw2_ff <= `SW2_PARAM; // RULE5
			end
			else if (get_cmd && pending_ff)
			begin
				sw1_ff <= `SW1_OK; // RULE6
				sw2_ff <= `SW2_NONE;
			end
			else if (!direct_ok)
			begin
				sw1_ff <= `SW1_ERR; // RULE8
				sw2_ff <= `SW2_GENERAL; // RULE8
			end
		end
	end

	// waiting reply; set by the front end, taken by one fetch
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			pending_ff                 <= 1'b0;
			pending_response_length_ff <= 8'h00;
		end
		else if (fe_end && (fe_status == FE_OK))
		begin
			pending_ff                 <= 1'b1;
			pending_response_length_ff <= fe_resp_len;
		end
		else if ((exec_go && get_cmd) || fe_end || fe_timeout)
			pending_ff <= 1'b0;
	end

	// fetch window over the reply buffer
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			left_ff   <= 8'h00;
			rd_ptr_ff <= 8'h00;
		end
		else if (exec_go && get_cmd)
		begin
			left_ff   <= pending_ff ? get_len : 8'h00; // RULE6
			rd_ptr_ff <= 8'h00;
		end
		else if (exec_go && direct_ok)
			left_ff <= 8'h00;
		else if (resp_pop)
		begin
			left_ff   <= left_ff - 8'h01;
			rd_ptr_ff <= rd_ptr_ff + 8'h01;
		end
	end

	// ************************************************************
	// register read port
	// ************************************************************
	always_ff @(posedge core_clk)
	begin
		if (!resetn || !reg_rd)
			rdata_ff <= 32'h0;
		else
			unique case (reg_addr)
				`REG_STATUS:    rdata_ff <= {busy_ff, pending_ff, 14'h0, sw1_ff, sw2_ff};
				`REG_RESP_DATA: rdata_ff <= resp_pop ? {24'h0, resp_mem[rd_ptr_ff]} : 32'h0;
				`REG_LAMP:      rdata_ff <= {29'h0, buzz, lamp};
				`REG_RESP_LEFT: rdata_ff <= {16'h0, pending_response_length_ff, left_ff};
				default:        rdata_ff <= 32'h0;
			endcase
	end

	// ************************************************************
	// lamp and buzzer sequence
	// ************************************************************
	tick_gen #(
		.CYCLES   (TICK_CYCLES)
	) u_tick (
		.core_clk (core_clk),
		.resetn   (resetn),
		.clear    (lamp_start),
		.tick_ff  (tick)
	);

	blink_seq u_seq (
		.core_clk (core_clk),
		.resetn   (resetn),
		.tick     (tick),
		.start    (lamp_start),
		.ctrl_in  (cmd_mem[3]),
		.ini_in   (cmd_mem[5]),
		.tog_in   (cmd_mem[6]),
		.reps_in  (cmd_mem[7]),
		.link_in  (cmd_mem[8]),
		.lamp_ff  (lamp),
		.buzz_ff  (buzz)
	);

	assign reg_rdata  = rdata_ff;
	assign fe_req     = fe_req_ff;
	assign fe_cmd_len = fe_cmd_len_ff;
	assign fe_rd_data = fe_rd_data_ff;
	assign red_led    = lamp[0];
	assign green_led  = lamp[1];
	assign buzzer     = buzz;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	a_more_status: assert property (fe_end && (fe_status == FE_OK) // RULE1
		|=> (sw1_ff == 8'h61) && (sw2_ff == $past(fe_resp_len)) && pending_ff)
		else $error("success status not 61 len");

	a_general_fail: assert property (fe_end && (fe_status == FE_GENERAL) // RULE2
		|=> (sw1_ff == 8'h63) && (sw2_ff == 8'h00) && !busy_ff)
		else $error("general failure not 63 00");

	a_timeout_status: assert property (fe_timeout // RULE3
		|=> (sw1_ff == 8'h63) && (sw2_ff == 8'h01) && !busy_ff && !pending_ff)
		else $error("timeout not 63 01");

	a_checksum_status: assert property (fe_end && (fe_status == FE_CHECKSUM) // RULE4
		|=> (sw1_ff == 8'h63) && (sw2_ff == 8'h27))
		else $error("checksum error not 63 27");

	a_param_status: assert property (exec_go && direct_cmd && !direct_ok // RULE5
		|=> (sw1_ff == 8'h63) && (sw2_ff == 8'h7F) && !fe_req && !busy_ff)
		else $error("malformed command not 63 7F");

	a_fetch_window: assert property (exec_go && get_cmd && pending_ff // RULE6
		|=> (left_ff <= $past(cmd_mem[4])) && !pending_ff && (sw1_ff == 8'h90)) // RULE7
		else $error("fetch window wrong");

	a_fetch_empty: assert property (exec_go && get_cmd && !pending_ff // RULE8
		|=> (sw1_ff == 8'h63) && (sw2_ff == 8'h00) && (left_ff == 8'h00))
		else $error("empty fetch not 63 00");

	a_lamp_answer: assert property (lamp_start // RULE16
		|=> (sw1_ff == 8'h90) && (sw2_ff == {6'h00, $past(lamp)})) // RULE10
		else $error("lamp command answer wrong");

	a_launch_once: assert property (exec_go && direct_ok
		|=> fe_req && busy_ff ##1 !fe_req)
		else $error("front-end request not one pulse");

endmodule : apdu_handler

`default_nettype wire

/* File: test/fe_model.sv */
`timescale 1ns/1ps
`default_nettype none

module fe_model
(
	input  wire logic       core_clk,    // system clock
	input  wire logic       fe_req,      // launch pulse
	input  wire logic [7:0] fe_rd_data,  // embedded byte
	input  wire logic [1:0] mode,        // result to give
	input  wire logic       silent,      // never answer
	output logic      [7:0] fe_rd_addr,  // byte wanted
	output logic            fe_done,     // finished
	output logic      [1:0] fe_status,   // result code
	output logic      [7:0] fe_resp_len, // reply count
	output logic            fe_wr,       // reply strobe
	output logic      [7:0] fe_wr_data   // reply byte
);
	logic [7:0] base;
	int         step = 99;

	initial
	begin
		fe_done = 1'b0;
		fe_wr = 1'b0;
		fe_wr_data = 8'h00;
		fe_status = 2'h0;
		fe_resp_len = 8'h00;
	end
	assign fe_rd_addr = 8'h00;

	// read byte 0, reply it plus index three times, then finish
	always @(posedge core_clk)
	begin
		fe_wr <= 1'b0;
		fe_done <= 1'b0;
		fe_wr_data <= ~fe_wr_data; // no stale byte between strobes
		step <= fe_req ? 0 : step + 1;
		if (step == 2)
			base <= fe_rd_data;
		if (step >= 3 && step <= 5 && !silent)
		begin
			fe_wr <= 1'b1;
			fe_wr_data <= base + 8'(step - 3);
		end
		if (step == 6 && !silent)
		begin
			fe_done <= 1'b1;
			fe_status <= mode;
			fe_resp_len <= 8'h03;
		end
	end
endmodule : fe_model

`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "apdu_cfg.svh"

module tb_top;
	logic        core_clk, resetn, reg_wr, reg_rd, fe_req, fe_done, fe_wr, silent;
	logic        red_led, green_led, buzzer;
	logic [7:0]  reg_addr, fe_cmd_len, fe_rd_addr, fe_rd_data, fe_resp_len, fe_wr_data;
	logic [31:0] reg_wdata, reg_rdata, d;
	logic [1:0]  fe_status, mode;
	int          fails, cmp_count, n;

	apdu_handler #(.TICK_CYCLES(10), .FE_TO_CYCLES(50)) dut (.core_clk, .resetn,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .fe_req, .fe_cmd_len,
		.fe_rd_addr, .fe_rd_data, .fe_done, .fe_status, .fe_resp_len, .fe_wr,
		.fe_wr_data, .red_led, .green_led, .buzzer);
	fe_model fe (.core_clk, .fe_req, .fe_rd_data, .mode, .silent, .fe_rd_addr,
		.fe_done, .fe_status, .fe_resp_len, .fe_wr, .fe_wr_data);

	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict

	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			fails++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd

	task automatic cmd(input logic [7:0] b[$]);
		foreach (b[i])
			wr(`REG_CMD_BYTE, {24'h0, b[i]});
		wr(`REG_CMD_EXEC, 32'h0);
	endtask : cmd

	// poll until not busy, then compare the status word
	task automatic sts(input logic [31:0] e);
		for (n = 0; n < 40 && d[31] !== 1'b0; n++)
			rd(`REG_STATUS);
		chk("status", e, d);
		if (n == 40)
			print_verdict();
		d = 32'hFFFF_FFFF;
	endtask : sts

	// wait for lamp levels {buzzer, green, red}, check the wait length
	task automatic lamp(input logic [2:0] e, input int lo, input int hi);
		#1;
		for (n = 0; n < 100 && {buzzer, green_led, red_led} !== e; n++)
		begin
			@(posedge core_clk);
			#1;
		end
		chk("lamps", {29'h0, e}, {29'h0, buzzer, green_led, red_led});
		chk("phase", 1, {31'h0, n >= lo && n <= hi});
		if (n == 100)
			print_verdict();
	endtask : lamp

	task automatic t_reset;
		sts(32'h0000_9000);
		rd(`REG_LAMP);
		chk("lamp reg", 32'h0, d);
		rd(8'h18);
		chk("unmapped", 32'h0, d);
		d = 32'hFFFF_FFFF;
		cmd('{8'hFF, 8'hC0, 8'h00, 8'h00, 8'h05});
		sts(32'h0000_6300);
	endtask : t_reset

	task automatic t_pass;
		cmd('{8'hFF, 8'h00, 8'h00, 8'h00, 8'h02, 8'hA5, 8'h5A});
		sts(32'h4000_6103);
		chk("cmd len", 32'h2, {24'h0, fe_cmd_len});
		cmd('{8'hFF, 8'hC0, 8'h00, 8'h00, 8'hFF});
		sts(32'h0000_9000);
		rd(`REG_RESP_LEFT);
		chk("left", 32'h0000_0303, d);
		for (int k = 0; k < 4; k++)
		begin
			rd(`REG_RESP_DATA);
			chk("reply", (k < 3) ? 32'hA5 + k : 32'h0, d);
		end
		rd(`REG_RESP_LEFT);
		chk("left", 32'h0000_0300, d);
		d = 32'hFFFF_FFFF;
		cmd('{8'hFF, 8'hC0, 8'h00, 8'h00, 8'h03});
		sts(32'h0000_6300);
	endtask : t_pass

	task automatic t_fail;
		logic [7:0] sw2[4] = '{8'h00, 8'h00, 8'h27, 8'h00};
		for (int m = 1; m < 4; m++)
		begin
			mode <= 2'(m);
			cmd('{8'hFF, 8'h00, 8'h00, 8'h00, 8'h01, 8'h33});
			sts({16'h0, 8'h63, sw2[m]});
		end
		silent <= 1'b1;
		cmd('{8'hFF, 8'h00, 8'h00, 8'h00, 8'h01, 8'h33});
		sts(32'h0000_6301);
		silent <= 1'b0;
		cmd('{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00});
		sts(32'h0000_637F);
		cmd('{8'hFF, 8'h00, 8'h00, 8'h00, 8'h03, 8'h11});
		sts(32'h0000_637F);
		// 261 bytes of an otherwise valid pass-through: overflow must refuse it
		for (int k = 0; k < 261; k++)
			wr(`REG_CMD_BYTE, {24'h0, (k == 0 || k == 4) ? 8'hFF : 8'h00});
		wr(`REG_CMD_EXEC, 32'h0);
		sts(32'h0000_6300);
		cmd('{8'hFF, 8'h00, 8'h40, 8'h00, 8'h04, 8'h01, 8'h01, 8'h01});
		sts(32'h0000_6300);
	endtask : t_fail

	// red blinks from on, green final on, buzzer in initial phase
	task automatic t_blink;
		cmd('{8'hFF, 8'h00, 8'h40, 8'h5A, 8'h04, 8'h02, 8'h01, 8'h02, 8'h01});
		lamp(3'b101, 0, 2);
		lamp(3'b000, 19, 23);
		lamp(3'b101, 9, 13);
		lamp(3'b000, 19, 23);
		lamp(3'b010, 9, 13);
		sts(32'h0000_9000);
	endtask : t_blink

	task automatic t_noblink;
		cmd('{8'hFF, 8'h00, 8'h40, 8'hC5, 8'h04, 8'h01, 8'h01, 8'h00, 8'h03});
		lamp(3'b011, 0, 2);
		repeat (30) @(posedge core_clk);
		lamp(3'b011, 0, 0);
		rd(`REG_LAMP);
		chk("lamp reg", 32'h3, d);
		d = 32'hFFFF_FFFF;
		sts(32'h0000_9002);
	endtask : t_noblink

	initial
	begin
		{resetn, reg_wr, reg_rd, silent, reg_addr, reg_wdata, mode} = '0;
		{fails, cmp_count} = '0;
		d = 32'hFFFF_FFFF;
		repeat (4) @(posedge core_clk);
		resetn <= 1'b1;
		t_reset();
		t_pass();
		t_fail();
		t_blink();
		t_noblink();
		print_verdict();
	end
endmodule : tb_top

`default_nettype wire
